// [src/crcx_params.svh]
`ifndef CRCX_PARAMS_SVH
`define CRCX_PARAMS_SVH

// ----------------------------------------------------------------
// Checksum unit map (byte addresses on the link)
// ----------------------------------------------------------------
`define CRCX_OFS_DATA      8'h00
`define CRCX_OFS_CTRL      8'h08
`define CRCX_OFS_INIT      8'h10
`define CRCX_OFS_GENERATOR_VALUE      8'h14
// Control fields
`define CRCX_CTRL_RESET    0
`define CRCX_CTRL_WID_LO   3
`define CRCX_CTRL_WID_HI   4
`define CRCX_CTRL_RIN_LO   5
`define CRCX_CTRL_RIN_HI   6
`define CRCX_CTRL_ROUT     7
`define CRCX_INIT_RST      32'hFFFFFFFF
`define CRCX_GENERATOR_VALUE_RST      32'h04C11DB7

// ----------------------------------------------------------------
// Transfer engine map (byte addresses on the software port)
// ----------------------------------------------------------------
`define CRCX_DMA_CTRL      8'h00
`define CRCX_DMA_SRC       8'h04
`define CRCX_DMA_DST       8'h08
`define CRCX_DMA_CNT       8'h0C
`define CRCX_DMA_STAT      8'h10
`define CRCX_DMA_IEN       8'h14
`define CRCX_DMA_ICLR      8'h18
`define CRCX_DMA_LADDR     8'h1C
`define CRCX_DMA_LWDATA    8'h20
`define CRCX_DMA_LGO       8'h24
`define CRCX_DMA_LRDATA    8'h28
`define CRCX_DMA_EN_BIT    0
`define CRCX_EV_DONE       0
`define CRCX_EV_LINK       1
`define CRCX_EV_W          2

`endif

// [src/crcx_pkg.sv]
package crcx_pkg;

  // Element size on the link
  typedef enum logic [1:0] {
    CRCX_SZ_BYTE = 2'h0,
    CRCX_SZ_HALF = 2'h1,
    CRCX_SZ_WORD = 2'h2
  } crcx_size_e;

  // Generator width select
  typedef enum logic [1:0] {
    CRCX_W32 = 2'h0,
    CRCX_W16 = 2'h1,
    CRCX_W8  = 2'h2,
    CRCX_W7  = 2'h3
  } crcx_width_e;

  typedef enum logic [6:0] {
    CRCX_IDLE  = 7'b0000001,
    CRCX_FETCH = 7'b0000010,
    CRCX_CATCH = 7'b0000100,
    CRCX_PUSH  = 7'b0001000,
    CRCX_DONE  = 7'b0010000,
    CRCX_SWOP  = 7'b0100000,
    CRCX_SWCAP = 7'b1000000
  } crcx_dma_state_e;

endpackage : crcx_pkg

// [src/crcx_link_if.sv]
`timescale 1ns/10ps
interface crcx_link_if;
  logic [7:0]  addr;  // Byte address of register
  logic [31:0] wdata; // Write data, element in low bits
  logic        wr;    // Write request, held while stall
  logic        rd;    // Read request, held while stall
  logic [1:0]  size;  // Element size of a write
  logic [31:0] rdata; // Read data, cycle after acceptance
  logic        stall; // Wait state

  modport crcDev (input addr, input wdata, input wr, input rd, input size, output rdata, output stall);
  modport dmaMaster (output addr, output wdata, output wr, output rd, output size, input rdata, input stall);
endinterface : crcx_link_if

// [src/crcx_unit.sv]
// Summary of operation
// - One 32-bit data register: write input, read checksum
// - Full variant buffers a word during calculation
// - Full variant reverses input and output bits
// - Initial value fixed ones, or programmable
// - Full variant takes 8/16/32-bit elements
// - Generator width 7/8/16/32, basic fixed 32-bit width and polynomial
// - Engine streams source elements to fixed data address
// - Element size is byte, half-word or word
// - Count down, then raise completion interrupt
// - Stream type self-disables; channel needs software disable
// - Configure everything before enabling the channel
// - Each write folds input into stored checksum
// - XOR in, shift left, XOR generator on carry
// - Reset bit loads initial value into checksum
`timescale 1ns/10ps
`include "crcx_params.svh"
module crcx_unit import crcx_pkg::*; #(
  parameter bit          FULL     = 1'b1,
  parameter logic [31:0] INIT_DEF = `CRCX_INIT_RST,
  parameter logic [31:0] GENERATOR_VALUE_DEF = `CRCX_GENERATOR_VALUE_RST
) (
  input  wire logic        core_clk, // System clock
  input  wire logic        rst,      // Async reset, high
  crcx_link_if.crcDev      lnk,      // Register link
  output logic [31:0]      checksum, // Current result as read
  output logic             calcBusy  // Calculation or buffer pending
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] revUnit(input logic [31:0] d, input int g);
    logic [31:0] o;
    o = 32'h0;
    for (int i = 0; i < 32; i++) begin
      o[i] = d[(i / g) * g + g - 1 - (i % g)];
    end
    return o;
  endfunction : revUnit

  function automatic logic [4:0] msbOf(input logic [1:0] w);
    case (w)
      CRCX_W16: msbOf = 5'd15;
      CRCX_W8:  msbOf = 5'd7;
      CRCX_W7:  msbOf = 5'd6;
      default:  msbOf = 5'd31;
    endcase
  endfunction : msbOf

  function automatic logic [31:0] revOutFn(input logic [31:0] c, input logic [4:0] m);
    logic [31:0] o;
    o = 32'h0;
    for (int i = 0; i < 32; i++) begin
      if (i <= int'(m)) begin
        o[i] = c[int'(m) - i];
      end
    end
    return o;
  endfunction : revOutFn

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] crc;
  logic [1:0]  ctrlWidth;
  logic [1:0]  revIn;
  logic        revOut;
  logic [31:0] initVal;
  logic [31:0] polyVal;
  logic        bufValid;
  logic [31:0] bufData;
  logic [1:0]  bufSize;
  logic        busy;
  logic [5:0]  bitCnt;
  logic [31:0] shReg;

  logic        hitData;
  logic        hitCtrl;
  logic        hitInit;
  logic        hitPoly;
  logic        accept;
  logic        start;
  logic        wrCtrl;
  logic [1:0]  sizeEff;
  logic [1:0]  widthEff;
  logic [1:0]  revInEff;
  logic        revOutEff;
  logic [31:0] initEff;
  logic [31:0] polyEff;
  logic [4:0]  msb;
  logic [31:0] mask;
  logic [31:0] ctrlMask;
  logic [31:0] alignIn;
  logic        feedBit;
  logic [31:0] next_crc;
  logic [31:0] readVal;
  int          gran;

  // ----------------------------------------------------------------
  // Decode and wait states
  // ----------------------------------------------------------------
  assign hitData = lnk.addr == `CRCX_OFS_DATA;
  assign hitCtrl = lnk.addr == `CRCX_OFS_CTRL;
  assign hitInit = lnk.addr == `CRCX_OFS_INIT;
  assign hitPoly = lnk.addr == `CRCX_OFS_GENERATOR_VALUE;

  // Buffer takes a word even mid-calculation on the full variant
  assign accept  = lnk.wr && hitData && !bufValid && (FULL || !busy);
  assign start   = bufValid && !busy;
  // Data reads wait until every written element is folded in
  assign lnk.stall = (lnk.wr && hitData && !accept)
                   || (((lnk.rd && hitData) || (lnk.wr && hitCtrl)) && (busy || bufValid));
  assign wrCtrl  = lnk.wr && hitCtrl && !lnk.stall;
  assign calcBusy = busy || bufValid;

  // Basic variant: fixed word size, width, generator, init, no reversal
  assign sizeEff   = FULL ? lnk.size : CRCX_SZ_WORD;
  assign widthEff  = FULL ? ctrlWidth : CRCX_W32;
  assign revInEff  = FULL ? revIn : 2'h0;
  assign revOutEff = FULL ? revOut : 1'b0;
  assign initEff   = FULL ? initVal : `CRCX_INIT_RST;
  assign polyEff   = FULL ? polyVal : `CRCX_GENERATOR_VALUE_RST;
  assign msb       = msbOf(widthEff);
  assign mask      = 32'hFFFFFFFF >> (5'd31 - msb);
  // Reset must use the width written beside it, not the old one
  assign ctrlMask  = 32'hFFFFFFFF >> (5'd31 - msbOf(FULL ? lnk.wdata[`CRCX_CTRL_WID_HI:`CRCX_CTRL_WID_LO] : CRCX_W32));

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlWidth <= CRCX_W32;
      revIn     <= 2'h0;
      revOut    <= 1'b0;
    end else if (wrCtrl) begin
      ctrlWidth <= lnk.wdata[`CRCX_CTRL_WID_HI:`CRCX_CTRL_WID_LO];
      revIn     <= lnk.wdata[`CRCX_CTRL_RIN_HI:`CRCX_CTRL_RIN_LO];
      revOut    <= lnk.wdata[`CRCX_CTRL_ROUT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      initVal <= INIT_DEF;
      polyVal <= GENERATOR_VALUE_DEF;
    end else begin
      if (lnk.wr && hitInit) begin
        initVal <= lnk.wdata;
      end
      if (lnk.wr && hitPoly) begin
        polyVal <= lnk.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bufValid <= 1'b0;
      bufData  <= 32'h0;
      bufSize  <= CRCX_SZ_WORD;
    end else if (accept) begin
      bufValid <= 1'b1;
      bufData  <= lnk.wdata;
      bufSize  <= sizeEff;
    end else if (start) begin
      bufValid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit-serial engine, one input bit per clock
  // ----------------------------------------------------------------
  always_comb begin
    gran = 32;
    if (revInEff == 2'h1 || bufSize == CRCX_SZ_BYTE) begin
      gran = 8;
    end else if (revInEff == 2'h2 || bufSize == CRCX_SZ_HALF) begin
      gran = 16;
    end
    alignIn = (revInEff != 2'h0) ? revUnit(bufData, gran) : bufData;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy   <= 1'b0;
      bitCnt <= 6'h0;
      shReg  <= 32'h0;
    end else if (start) begin
      busy <= 1'b1;
      case (bufSize)
        CRCX_SZ_BYTE: begin
          shReg  <= {alignIn[7:0], 24'h0};
          bitCnt <= 6'd8;
        end
        CRCX_SZ_HALF: begin
          shReg  <= {alignIn[15:0], 16'h0};
          bitCnt <= 6'd16;
        end
        default: begin
          shReg  <= alignIn;
          bitCnt <= 6'd32;
        end
      endcase
    end else if (busy) begin
      shReg  <= {shReg[30:0], 1'b0};
      bitCnt <= bitCnt - 6'd1;
      if (bitCnt == 6'd1) begin
        busy <= 1'b0;
      end
    end
  end

  // XOR of input bit into the top bit equals XOR-in-then-shift
  assign feedBit  = crc[msb] ^ shReg[31];
  assign next_crc = ({crc[30:0], 1'b0} ^ (feedBit ? polyEff : 32'h0)) & mask;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crc <= INIT_DEF;
    end else if (wrCtrl && lnk.wdata[`CRCX_CTRL_RESET]) begin
      crc <= initEff & ctrlMask;
    end else if (busy) begin
      crc <= next_crc;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign readVal = revOutEff ? revOutFn(crc, msb) : (crc & mask);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lnk.rdata <= 32'h0;
    end else if (lnk.rd && !lnk.stall) begin
      if (hitData) begin
        lnk.rdata <= readVal;
      end else if (hitCtrl) begin
        lnk.rdata <= {24'h0, revOutEff, revInEff, widthEff, 3'h0};
      end else if (hitInit) begin
        lnk.rdata <= initEff;
      end else if (hitPoly) begin
        lnk.rdata <= polyEff;
      end else begin
        lnk.rdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      checksum <= 32'h0;
    end else begin
      checksum <= readVal;
    end
  end

endmodule : crcx_unit

// [src/crcx_dma.sv]
`timescale 1ns/10ps
`include "crcx_params.svh"
module crcx_dma import crcx_pkg::*; #(
  parameter bit CHAN_TYPE = 1'b0, // 1: software must disable
  parameter int CNT_W     = 16
) (
  input  wire logic        core_clk,  // System clock
  input  wire logic        rst,       // Async reset, high
  crcx_link_if.dmaMaster   lnk,       // Link to checksum unit
  input  wire logic [7:0]  regAddr,   // Software port address
  input  wire logic [31:0] regWdata,  // Software write data
  input  wire logic        regWr,     // Software write strobe
  input  wire logic        regRd,     // Software read strobe
  output logic [31:0]      regRdata,  // Read data, next cycle
  output logic [31:0]      memAddr,   // Source byte address
  output logic             memRd,     // Source read strobe
  input  wire logic [31:0] memRdata,  // Source word, next cycle
  output logic             irq        // Level interrupt
);

  crcx_dma_state_e        state;
  logic                   enable;
  logic [1:0]             elemSize;
  logic [31:0]            dstPtr;
  logic [CNT_W-1:0]       count;
  logic [`CRCX_EV_W-1:0]  status;
  logic [`CRCX_EV_W-1:0]  irqEn;
  logic [`CRCX_EV_W-1:0]  evSet;
  logic [7:0]             swAddr;
  logic [31:0]            swWdata;
  logic [31:0]            swRdata;
  logic                   swWrite;
  logic [1:0]             swSize;
  logic                   swPend;
  logic                   pushOk;
  logic                   lastElem;
  logic [31:0]            step;
  logic [31:0]            lane;

  assign pushOk   = state == CRCX_PUSH && !lnk.stall;
  assign lastElem = count == CNT_W'(1);
  assign memRd    = state == CRCX_FETCH;
  assign lnk.wr   = state == CRCX_PUSH || (state == CRCX_SWOP && swWrite);
  assign lnk.rd   = state == CRCX_SWOP && !swWrite;
  assign step     = (elemSize == CRCX_SZ_BYTE) ? 32'h1 : (elemSize == CRCX_SZ_HALF) ? 32'h2 : 32'h4;
  assign evSet[`CRCX_EV_DONE] = pushOk && lastElem || (state == CRCX_IDLE && enable && count == '0);
  assign evSet[`CRCX_EV_LINK] = (state == CRCX_SWOP && swWrite && !lnk.stall) || state == CRCX_SWCAP;

  always_comb begin
    case (elemSize)
      CRCX_SZ_BYTE: lane = {24'h0, memRdata[{memAddr[1:0], 3'h0} +: 8]};
      CRCX_SZ_HALF: lane = {16'h0, memRdata[{memAddr[1], 4'h0} +: 16]};
      default:      lane = memRdata;
    endcase
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= CRCX_IDLE;
    end else begin
      case (state)
        CRCX_IDLE: begin
          if (enable) begin
            state <= (count == '0) ? CRCX_DONE : CRCX_FETCH;
          end else if (swPend) begin
            state <= CRCX_SWOP;
          end
        end
        CRCX_FETCH: state <= CRCX_CATCH;
        CRCX_CATCH: state <= CRCX_PUSH;
        CRCX_PUSH: begin
          if (pushOk) begin
            state <= lastElem ? CRCX_DONE : CRCX_FETCH;
          end
        end
        // Channel type parks here until software disables
        CRCX_DONE: begin
          if (!enable) begin
            state <= CRCX_IDLE;
          end
        end
        CRCX_SWOP: begin
          if (!lnk.stall) begin
            state <= swWrite ? CRCX_IDLE : CRCX_SWCAP;
          end
        end
        default: state <= CRCX_IDLE;
      endcase
    end
  end

  // Enable: software sets, stream type clears itself at the end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
    end else if (!CHAN_TYPE && evSet[`CRCX_EV_DONE]) begin
      enable <= 1'b0;
    end else if (regWr && regAddr == `CRCX_DMA_CTRL) begin
      enable <= regWdata[`CRCX_DMA_EN_BIT];
    end
  end

  // Source pointer and count: loaded by software, stepped per element
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memAddr  <= 32'h0;
      count    <= '0;
      dstPtr   <= 32'h0;
      elemSize <= CRCX_SZ_WORD;
    end else if (pushOk) begin
      memAddr <= memAddr + step;
      count   <= count - CNT_W'(1);
    end else if (regWr && state == CRCX_IDLE) begin
      if (regAddr == `CRCX_DMA_SRC) begin
        memAddr <= regWdata;
      end else if (regAddr == `CRCX_DMA_DST) begin
        dstPtr <= regWdata;
      end else if (regAddr == `CRCX_DMA_CNT) begin
        count <= regWdata[CNT_W-1:0];
      end else if (regAddr == `CRCX_DMA_CTRL) begin
        elemSize <= regWdata[2:1];
      end
    end
  end

  // Link address, data and size
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lnk.addr  <= 8'h0;
      lnk.wdata <= 32'h0;
      lnk.size  <= CRCX_SZ_WORD;
    end else if (state == CRCX_CATCH) begin
      lnk.addr  <= dstPtr[7:0];
      lnk.wdata <= lane;
      lnk.size  <= elemSize;
    end else if (state == CRCX_IDLE && !enable && swPend) begin
      lnk.addr  <= swAddr;
      lnk.wdata <= swWdata;
      lnk.size  <= swSize;
    end
  end

  // ----------------------------------------------------------------
  // Software link access and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swAddr  <= 8'h0;
      swWdata <= 32'h0;
      swWrite <= 1'b0;
      swSize  <= CRCX_SZ_WORD;
      swPend  <= 1'b0;
    end else begin
      if (regWr && regAddr == `CRCX_DMA_LADDR) begin
        swAddr <= regWdata[7:0];
      end
      if (regWr && regAddr == `CRCX_DMA_LWDATA) begin
        swWdata <= regWdata;
      end
      if (regWr && regAddr == `CRCX_DMA_LGO && !swPend) begin
        swWrite <= regWdata[0];
        swSize  <= regWdata[2:1];
        swPend  <= 1'b1;
      end else if (state == CRCX_IDLE && !enable && swPend) begin
        swPend <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swRdata <= 32'h0;
    end else if (state == CRCX_SWCAP) begin
      swRdata <= lnk.rdata;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (regWr && regAddr == `CRCX_DMA_ICLR) begin
      status <= (status & ~regWdata[`CRCX_EV_W-1:0]) | evSet;
    end else begin
      status <= status | evSet;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqEn <= '0;
    end else if (regWr && regAddr == `CRCX_DMA_IEN) begin
      irqEn <= regWdata[`CRCX_EV_W-1:0];
    end
  end

  assign irq = |(status & irqEn);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      if (regAddr == `CRCX_DMA_CTRL) begin
        regRdata <= {28'h0, state != CRCX_IDLE, elemSize, enable};
      end else if (regAddr == `CRCX_DMA_SRC) begin
        regRdata <= memAddr;
      end else if (regAddr == `CRCX_DMA_DST) begin
        regRdata <= dstPtr;
      end else if (regAddr == `CRCX_DMA_CNT) begin
        regRdata <= 32'(count);
      end else if (regAddr == `CRCX_DMA_STAT) begin
        regRdata <= {29'h0, swPend, 2'h0} | 32'(status);
      end else if (regAddr == `CRCX_DMA_IEN) begin
        regRdata <= 32'(irqEn);
      end else if (regAddr == `CRCX_DMA_LADDR) begin
        regRdata <= {24'h0, swAddr};
      end else if (regAddr == `CRCX_DMA_LWDATA) begin
        regRdata <= swWdata;
      end else if (regAddr == `CRCX_DMA_LRDATA) begin
        regRdata <= swRdata;
      end else begin
        regRdata <= 32'h0;
      end
    end
  end

endmodule : crcx_dma

// [sim/crcx_properties.sv]
`timescale 1ns/10ps
module crcx_properties (
  input wire logic        core_clk, // System clock
  input wire logic        rst,      // Async reset, high
  input wire logic [7:0]  addr,     // Link address
  input wire logic [31:0] wdata,    // Link write data
  input wire logic        wr,       // Link write request
  input wire logic        rd,       // Link read request
  input wire logic [1:0]  size,     // Element size
  input wire logic [31:0] rdata,    // Link read data
  input wire logic        stall     // Wait state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Link rules
  // ----------------------------------------------------------------
  a_wr_held_stall: assert property (wr && stall |=> wr && $stable(addr) && $stable(wdata) && $stable(size))
    else $error("write changed while stalled");
  a_rd_held_stall: assert property (rd && stall |=> rd && $stable(addr))
    else $error("read changed while stalled");
  a_no_dual_req: assert property (!(wr && rd))
    else $error("read and write at once");
  // Buffer drain plus one element stays well inside this
  a_stall_bounded: assert property ((wr || rd) && stall |-> ##[1:80] !stall)
    else $error("stall too long");
  a_size_legal: assert property (wr |-> size != 2'h3)
    else $error("illegal element size");
  a_rdata_holds: assert property (!$past(rd && !stall) |-> $stable(rdata))
    else $error("read data moved without a read");
  a_idle_after_reset: assert property ($past(rst) |-> !wr && !rd)
    else $error("request right after reset");
  a_single_burst: assert property (wr && !stall |=> !wr)
    else $error("write not single");
  c_stalled_write: cover property (wr && stall);
  c_read_taken: cover property (rd && !stall);
  c_byte_write: cover property (wr && !stall && size == 2'h0);
endmodule : crcx_properties

// [sim/tb.sv]
`timescale 1ns/10ps
`include "crcx_params.svh"
module tb;
  import crcx_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  regAddr  = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic [31:0] memRdata = 32'h0;
  logic [31:0] regRdata;
  logic [31:0] memAddr;
  logic        memRd;
  logic        irq;
  logic [31:0] checksum;
  logic        calcBusy;
  logic [31:0] mem [0:15];
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  crcx_link_if lnk ();
  crcx_unit u_crcx_unit (.core_clk(core_clk), .rst(rst), .lnk(lnk.crcDev), .checksum(checksum),
    .calcBusy(calcBusy));
  crcx_dma u_crcx_dma (.core_clk(core_clk), .rst(rst), .lnk(lnk.dmaMaster), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memAddr(memAddr), .memRd(memRd), .memRdata(memRdata),
    .irq(irq));
  crcx_properties u_crcx_properties (.core_clk(core_clk), .rst(rst), .addr(lnk.addr), .wdata(lnk.wdata),
    .wr(lnk.wr), .rd(lnk.rd), .size(lnk.size), .rdata(lnk.rdata), .stall(lnk.stall));

  always #2 core_clk = ~core_clk;
  // Source memory answers the cycle after the strobe
  always @(posedge core_clk) begin
    if (memRd) memRdata <= mem[memAddr[5:2]];
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic regW(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask : regW

  task automatic regR(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask : regR

  task automatic waitStat(input int b);
    logic [31:0] s;
    for (int k = 0; k < 400; k++) begin
      regR(`CRCX_DMA_STAT, s);
      if (s[b] === 1'b1) break;
    end
    check("status bit", {31'h0, s[b]}, 32'h1);
  endtask : waitStat

  task automatic linkOp(input logic [7:0] a, input logic [31:0] d, input logic wrn, input logic [1:0] sz,
                        output logic [31:0] r);
    regW(`CRCX_DMA_LADDR, {24'h0, a});
    regW(`CRCX_DMA_LWDATA, d);
    regW(`CRCX_DMA_LGO, {29'h0, sz, wrn});
    waitStat(`CRCX_EV_LINK);
    regW(`CRCX_DMA_ICLR, 32'h2);
    regR(`CRCX_DMA_LRDATA, r);
  endtask : linkOp

  // Bitwise model: xor each input bit at the top, shift, fold generator
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int nb, input int w,
                                       input logic [31:0] p);
    logic fb;
    for (int i = nb - 1; i >= 0; i--) begin
      fb = c[w-1] ^ d[i];
      c = 32'((c << 1) & ((64'h1 << w) - 1));
      if (fb) c = c ^ p;
    end
    return c;
  endfunction : fold

  // 8-bit generator, byte input, worked value
  task automatic smallWidth();
    logic [31:0] r;
    linkOp(`CRCX_OFS_INIT, 32'hFF, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_GENERATOR_VALUE, 32'hCB, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_CTRL, 32'h11, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_DATA, 32'h0, 1'b0, 2'h2, r);
    check("reset to init", r, 32'hFF);
    linkOp(`CRCX_OFS_DATA, 32'hC1, 1'b1, 2'h0, r);
    linkOp(`CRCX_OFS_DATA, 32'h0, 1'b0, 2'h2, r);
    check("8-bit checksum", r, 32'h4C);
    check("8-bit model", r, fold(32'hFF, 32'hC1, 8, 8, 32'hCB));
    // Byte input reversal and 8-bit output reversal: C1 enters as 83, 98 leaves as 19
    linkOp(`CRCX_OFS_CTRL, 32'hB1, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_DATA, 32'hC1, 1'b1, 2'h0, r);
    linkOp(`CRCX_OFS_DATA, 32'h0, 1'b0, 2'h2, r);
    check("reversed checksum", r, 32'h19);
  endtask : smallWidth

  task automatic xfer(input logic [1:0] sz, input int n, input logic ien);
    logic [31:0] r;
    logic [31:0] exp;
    logic [31:0] a;
    exp = 32'hFFFFFFFF;
    linkOp(`CRCX_OFS_INIT, 32'hFFFFFFFF, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_GENERATOR_VALUE, 32'h04C11DB7, 1'b1, 2'h2, r);
    linkOp(`CRCX_OFS_CTRL, 32'h01, 1'b1, 2'h2, r);
    regW(`CRCX_DMA_SRC, 32'h0);
    regW(`CRCX_DMA_DST, 32'h0);
    regW(`CRCX_DMA_CNT, 32'(n));
    regW(`CRCX_DMA_IEN, {31'h0, ien});
    regW(`CRCX_DMA_CTRL, {29'h0, sz, 1'b1});
    if (ien) begin
      for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge core_clk);
      check("irq raised", {31'h0, irq}, 32'h1);
    end else begin
      waitStat(`CRCX_EV_DONE);
      check("irq masked", {31'h0, irq}, 32'h0);
    end
    regR(`CRCX_DMA_CTRL, r);
    check("self disable", {31'h0, r[0]}, 32'h0);
    regW(`CRCX_DMA_ICLR, 32'h1);
    regR(`CRCX_DMA_STAT, r);
    check("done cleared", {31'h0, r[0] | irq}, 32'h0);
    for (int e = 0; e < n; e++) begin
      a = 32'(e) << sz;
      exp = fold(exp, mem[a[5:2]] >> (8 * a[1:0]), 8 << sz, 32, 32'h04C11DB7);
    end
    linkOp(`CRCX_OFS_DATA, 32'h0, 1'b0, 2'h2, r);
    check("stream checksum", r, exp);
    check("checksum output", checksum, exp);
    check("unit idle", {31'h0, calcBusy}, 32'h0);
  endtask : xfer

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'(32'h9E3779B9 * (i + 1));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    smallWidth();
    xfer(2'h2, 6, 1'b1);
    xfer(2'h0, 7, 1'b0);
    xfer(2'h1, 5, 1'b1);
    summarize();
  end
endmodule : tb
